//--- logic/reset_entry_and_register_init.sv
// Reset entry sequencer with peripheral register initialisation
// Overview of operation
// - Reset is left only after the pin returns high past the minimum low interval.
// - Execution starts at the address built from bytes at fffd (high) and fffc (low).
// - All port data and direction registers of ports 0 to 4 clear to zero.
// - The watchdog control register loads 0x3f.
// - The processor mode register loads 0x48.
// - Edge select, both request and both enable registers clear to zero.
// - The serial control register loads 0xe0 and the baud divider is left alone.
// - The pulse control register clears; its prescaler is left alone.
// - Timer mode and timer 2 clear, timer 1 loads 0x01, prescalers and X/Y load 0xff.
// - The timer source select register clears to zero.
// - The converter control register loads 0x10.
// - Undefined registers, processor status and RAM are not touched by reset.
// - Both watchdog counter halves preset to 0xff and stay stopped until a control write.
`timescale 1ns/1ps
module reset_entry_and_register_init
  import rst_init_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic main_osc_input,
  input wire logic reset_pin_n,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic cpu_run,
  output logic [15:0] start_pc,
  output logic [39:0] port_data,
  output logic [39:0] port_direction,
  output logic [7:0] watchdog_control,
  output logic [7:0] processor_mode_reg,
  output logic [7:0] async_serial_control,
  output logic [7:0] pulse_mod_control,
  output logic [7:0] converter_control,
  output logic wdog_running,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ******************************
  // Reset pin synchroniser and low counter
  // ******************************
  logic pin_s1_r;
  logic pin_s2_r;
  logic osc_d_r;
  logic [4:0] low_cnt_r;
  logic [4:0] low_cnt_nxt;
  logic low_ok_r;
  wire osc_rise = main_osc_input & ~osc_d_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      osc_d_r <= 1'b0;
    end else begin
      pin_s1_r <= reset_pin_n;
      pin_s2_r <= pin_s1_r;
      osc_d_r <= main_osc_input;
    end
  end
  // count oscillator edges while low; saturates at the minimum
  assign low_cnt_nxt = pin_s2_r ? 5'h00 :
    (osc_rise && low_cnt_r != MIN_LOW_CNT) ? low_cnt_r + 5'h01 : low_cnt_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      low_cnt_r <= 5'h00;
      low_ok_r <= 1'b0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
      low_ok_r <= pin_s2_r ? low_ok_r : (low_cnt_nxt == MIN_LOW_CNT);
    end
  end
  // ******************************
  // Sequencer
  // ******************************
  seq_e st_r;
  seq_e st_nxt;
  logic [7:0] pc_low_r;
  logic [7:0] pc_high_r;
  // Short low pulses never release: a glitch must not restart the CPU
  wire release_ok = pin_s2_r & low_ok_r;
  wire in_reset = (st_r != ST_RUN);
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_RESET: if (release_ok) st_nxt = ST_FETCH_LO;
      ST_FETCH_LO: st_nxt = ST_FETCH_HI;
      ST_FETCH_HI: st_nxt = ST_RUN;
      ST_RUN: if (!pin_s2_r) st_nxt = ST_RESET;
    endcase
  end
  // vector fetch, low byte then high byte
  assign mem_rd = (st_r == ST_FETCH_LO) | (st_r == ST_FETCH_HI);
  assign mem_addr = (st_r == ST_FETCH_HI) ? VEC_HIGH_ADDR : VEC_LOW_ADDR;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_RESET;
      pc_low_r <= 8'h00;
      pc_high_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      if (st_r == ST_FETCH_LO) pc_low_r <= mem_rdata;
      if (st_r == ST_FETCH_HI) pc_high_r <= mem_rdata;
    end
  end
  assign cpu_run = (st_r == ST_RUN);
  assign start_pc = {pc_high_r, pc_low_r};
  // ******************************
  // Avalon slave decode
  // ******************************
  wire wr_ports = avs_write & (avs_address == A_PORTS);
  wire wr_ctrl = avs_write & (avs_address == A_CTRL);
  wire wr_ints = avs_write & (avs_address == A_INTS);
  wire wr_tmr = avs_write & (avs_address == A_TIMERS);
  wire wr_presc = avs_write & (avs_address == A_PRESC);
  wire wr_soft = avs_write & (avs_address == A_SOFT_WR) & ~in_reset;
  // Writes are ignored while the sequence holds reset
  wire wr_live = ~in_reset;
  logic rd_ack_r;
  // Reads stall one cycle so the registered read data stands when the wait drops
  assign avs_waitrequest = avs_read & ~rd_ack_r;
  // ******************************
  // Initialised registers
  // ******************************
  logic [7:0] wdog_ctrl_r;
  logic [7:0] cpu_mode_r;
  logic [7:0] edge_sel_r;
  logic [7:0] req1_r;
  logic [7:0] req2_r;
  logic [7:0] en1_r;
  logic [7:0] en2_r;
  logic [7:0] serial_r;
  logic [7:0] pwm_ctrl_r;
  logic [7:0] tmr_mode_r;
  logic [7:0] tmr1_r;
  logic [7:0] tmr2_r;
  logic [7:0] prescaler_12_r;
  logic [7:0] prescaler_x_r;
  logic [7:0] prescaler_y_r;
  logic [7:0] tmrx_r;
  logic [7:0] tmry_r;
  logic [7:0] tmr_src_r;
  logic [7:0] conv_r;
  logic [7:0] wdog_h_r;
  logic [7:0] wdog_l_r;
  logic wdog_run_r;
  logic [7:0] baud_divider;
  logic [7:0] pulse_mod_prescaler;
  logic [7:0] processor_status;
  // per-port data and direction, loaded while in reset
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_port
      logic [7:0] dat_r;
      logic [7:0] dir_r;
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          dat_r <= PORT_RST;
          dir_r <= PORT_RST;
        end else if (in_reset) begin
          dat_r <= PORT_RST;
          dir_r <= PORT_RST;
        end else if (wr_ports && avs_byteenable[gi % 4] && gi < 4) begin
          dat_r <= avs_writedata[gi*8 % 32 +: 8];
        end
      end
      assign port_data[gi*8 +: 8] = dat_r;
      assign port_direction[gi*8 +: 8] = dir_r;
    end
  endgenerate
  // Control group: watchdog, mode, serial, pulse, converter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn || in_reset) begin
      wdog_ctrl_r <= WDOG_CTRL_RST;
      cpu_mode_r <= CPU_MODE_RST;
      serial_r <= SERIAL_CTRL_RST;
      pwm_ctrl_r <= PWM_CTRL_RST;
      conv_r <= CONV_CTRL_RST;
    end else if (wr_ctrl) begin
      if (avs_byteenable[0]) cpu_mode_r <= avs_writedata[7:0];
      if (avs_byteenable[1]) serial_r <= avs_writedata[15:8];
      if (avs_byteenable[2]) pwm_ctrl_r <= avs_writedata[23:16];
      if (avs_byteenable[3]) conv_r <= avs_writedata[31:24];
    end else if (wr_soft && avs_byteenable[0]) begin
      // control write sets the two upper bits; one driver for the whole byte
      wdog_ctrl_r[7:6] <= avs_writedata[7:6];
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn || in_reset) begin
      edge_sel_r <= INT_RST;
      req1_r <= INT_RST;
      req2_r <= INT_RST;
      en1_r <= INT_RST;
      en2_r <= INT_RST;
    end else if (wr_ints) begin
      if (avs_byteenable[0]) edge_sel_r <= avs_writedata[7:0];
      if (avs_byteenable[1]) en1_r <= avs_writedata[15:8];
      if (avs_byteenable[2]) en2_r <= avs_writedata[23:16];
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn || in_reset) begin
      tmr_mode_r <= TMR_MODE_RST;
      tmr1_r <= TMR1_RST;
      tmr2_r <= TMR2_RST;
      tmr_src_r <= TMR_SRC_RST;
      prescaler_12_r <= PRESCALE_RST;
      prescaler_x_r <= PRESCALE_RST;
      prescaler_y_r <= PRESCALE_RST;
      tmrx_r <= PRESCALE_RST;
      tmry_r <= PRESCALE_RST;
    end else begin
      if (wr_tmr && avs_byteenable[0]) tmr_mode_r <= avs_writedata[7:0];
      if (wr_tmr && avs_byteenable[1]) tmr1_r <= avs_writedata[15:8];
      if (wr_tmr && avs_byteenable[2]) tmr2_r <= avs_writedata[23:16];
      if (wr_tmr && avs_byteenable[3]) tmr_src_r <= avs_writedata[31:24];
      if (wr_presc && avs_byteenable[0]) prescaler_12_r <= avs_writedata[7:0];
      if (wr_presc && avs_byteenable[1]) prescaler_x_r <= avs_writedata[15:8];
      if (wr_presc && avs_byteenable[2]) prescaler_y_r <= avs_writedata[23:16];
    end
  end
  // watchdog counter preset; stays stopped until the first control write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn || in_reset) begin
      wdog_h_r <= WDOG_CNT_RST;
      wdog_l_r <= WDOG_CNT_RST;
      wdog_run_r <= 1'b0;
    end else if (wr_soft && avs_byteenable[0]) begin
      wdog_h_r <= WDOG_CNT_RST;
      wdog_l_r <= WDOG_CNT_RST;
      wdog_run_r <= 1'b1;
    end
  end
  // no reset branch: contents stay as software left them
  always_ff @(posedge clock) begin
    if (wr_presc && wr_live && avs_byteenable[3]) begin
      baud_divider <= avs_writedata[31:24];
      pulse_mod_prescaler <= avs_writedata[31:24];
      processor_status <= avs_writedata[31:24];
    end
  end
  assign watchdog_control = wdog_ctrl_r;
  assign processor_mode_reg = cpu_mode_r;
  assign async_serial_control = serial_r;
  assign pulse_mod_control = pwm_ctrl_r;
  assign converter_control = conv_r;
  assign wdog_running = wdog_run_r;
  // ******************************
  // Read mux
  // ******************************
  wire [31:0] rd_mux =
    (avs_address == A_STATUS) ? {28'h0000000, low_ok_r, pin_s2_r, st_r} :
    (avs_address == A_VECTOR) ? {16'h0000, start_pc} :
    (avs_address == A_PORTS) ? port_data[31:0] :
    (avs_address == A_CTRL) ? {conv_r, pwm_ctrl_r, serial_r, cpu_mode_r} :
    (avs_address == A_INTS) ? {req2_r, en2_r, en1_r, edge_sel_r} :
    (avs_address == A_TIMERS) ? {tmr_src_r, tmr2_r, tmr1_r, tmr_mode_r} :
    (avs_address == A_PRESC) ? {tmry_r, prescaler_y_r, prescaler_x_r, prescaler_12_r} :
    (avs_address == A_WDOG_CNT) ? {tmrx_r, wdog_ctrl_r, wdog_h_r, wdog_l_r} :
    UNMAPPED_VAL;
  // Read data loads in the stall cycle and holds until the next read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
      rd_ack_r <= 1'b0;
    end else begin
      avs_readdata <= (avs_read && !rd_ack_r) ? rd_mux : avs_readdata;
      rd_ack_r <= avs_read & ~rd_ack_r;
    end
  end
  // ******************************
  // Assertions
  // ******************************
  sequence s_fetch;
    st_r == ST_FETCH_LO ##1 st_r == ST_FETCH_HI ##1 st_r == ST_RUN;
  endsequence
  a_release_needs_count: assert property (@(posedge clock) disable iff (!rstn)
    (st_r == ST_RESET && st_nxt == ST_FETCH_LO) |-> low_ok_r && pin_s2_r)
    else $error("release without minimum low time");
  a_vector_fetch_order: assert property (@(posedge clock) disable iff (!rstn)
    (st_r == ST_RESET && release_ok) |=> s_fetch)
    else $error("vector fetch order wrong");
  a_vector_value: assert property (@(posedge clock) disable iff (!rstn)
    (st_r == ST_FETCH_HI) |=> start_pc == {$past(mem_rdata), pc_low_r})
    else $error("start address not assembled");
  a_ports_cleared: assert property (@(posedge clock) disable iff (!rstn)
    in_reset |=> port_direction == 40'h0 && port_data == 40'h0)
    else $error("ports not cleared");
  a_wdog_ctrl_init: assert property (@(posedge clock) disable iff (!rstn)
    in_reset |=> watchdog_control == WDOG_CTRL_RST)
    else $error("watchdog control wrong");
  a_mode_serial_init: assert property (@(posedge clock) disable iff (!rstn)
    in_reset |=> processor_mode_reg == CPU_MODE_RST && async_serial_control == SERIAL_CTRL_RST)
    else $error("mode or serial wrong");
  a_int_cleared: assert property (@(posedge clock) disable iff (!rstn)
    in_reset |=> (req1_r | req2_r | en1_r | en2_r | edge_sel_r) == 8'h00)
    else $error("interrupt regs not clear");
  a_timer_presets: assert property (@(posedge clock) disable iff (!rstn)
    in_reset |=> tmr1_r == TMR1_RST && tmrx_r == PRESCALE_RST && tmr_src_r == TMR_SRC_RST)
    else $error("timer presets wrong");
  a_conv_pwm_init: assert property (@(posedge clock) disable iff (!rstn)
    in_reset |=> converter_control == CONV_CTRL_RST && pulse_mod_control == PWM_CTRL_RST)
    else $error("converter or pulse control wrong");
  a_wdog_stopped: assert property (@(posedge clock) disable iff (!rstn)
    (cpu_run && !wdog_run_r && !wr_soft) |=> !wdog_run_r && wdog_h_r == WDOG_CNT_RST)
    else $error("watchdog started without write");
  a_sync_delay: assert property (@(posedge clock) disable iff (!rstn)
    (st_r == ST_RESET && low_ok_r && $rose(pin_s2_r)) |-> $past(pin_s1_r))
    else $error("release not synchronised");
endmodule : reset_entry_and_register_init

//--- logic/rst_init_pkg.sv
// Constants for the reset entry and register initialisation block
package rst_init_pkg;
  // ******************************
  // Timing
  // ******************************
  localparam int MIN_LOW_CYCLES = 20;
  localparam logic [4:0] MIN_LOW_CNT = 5'(MIN_LOW_CYCLES);
  // ******************************
  // Vector addresses
  // ******************************
  localparam logic [15:0] VEC_LOW_ADDR = 16'hfffc;
  localparam logic [15:0] VEC_HIGH_ADDR = 16'hfffd;
  // ******************************
  // Reset values
  // ******************************
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [7:0] WDOG_CTRL_RST = 8'h3f;
  localparam logic [7:0] CPU_MODE_RST = 8'h48;
  localparam logic [7:0] INT_RST = 8'h00;
  localparam logic [7:0] SERIAL_CTRL_RST = 8'he0;
  localparam logic [7:0] PWM_CTRL_RST = 8'h00;
  localparam logic [7:0] TMR_MODE_RST = 8'h00;
  localparam logic [7:0] TMR2_RST = 8'h00;
  localparam logic [7:0] TMR1_RST = 8'h01;
  localparam logic [7:0] PRESCALE_RST = 8'hff;
  localparam logic [7:0] TMR_SRC_RST = 8'h00;
  localparam logic [7:0] CONV_CTRL_RST = 8'h10;
  localparam logic [7:0] WDOG_CNT_RST = 8'hff;
  // ******************************
  // Avalon register map (word index = byte address / 4)
  // ******************************
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_VECTOR = 4'h1;
  localparam logic [3:0] A_PORTS = 4'h2;
  localparam logic [3:0] A_CTRL = 4'h3;
  localparam logic [3:0] A_INTS = 4'h4;
  localparam logic [3:0] A_TIMERS = 4'h5;
  localparam logic [3:0] A_PRESC = 4'h6;
  localparam logic [3:0] A_WDOG_CNT = 4'h7;
  localparam logic [3:0] A_SOFT_WR = 4'h8;
  localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_FETCH_LO = 2'b01,
    ST_FETCH_HI = 2'b11,
    ST_RUN = 2'b10
  } seq_e;
endpackage : rst_init_pkg

//--- sim/reset_source_model.sv
// Behavioural reset supervisor, oscillator and vector memory
`timescale 1ns/1ps
module reset_source_model
  import rst_init_pkg::*;
#(
  parameter logic [7:0] VEC_LO = 8'h5a,
  parameter logic [7:0] VEC_HI = 8'hc3
)(
  input wire logic clock,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata,
  output logic main_osc_input,
  output logic reset_pin_n
);
  // ****************************
  // Oscillator and memory
  // ****************************
  logic [1:0] div_r = 2'b00;
  logic [7:0] junk_r = 8'h00;
  initial main_osc_input = 1'b0;
  initial reset_pin_n = 1'b1;
  // Quarter-rate oscillator: one rising edge every 4 clocks, so counts are exact
  always @(posedge clock) begin
    div_r <= div_r + 2'd1;
    main_osc_input <= div_r[1];
    junk_r <= junk_r + 8'h35;
  end
  // Unselected memory shows a moving pattern, never a stale byte
  assign mem_rdata = !mem_rd ? junk_r : (mem_addr == VEC_LOW_ADDR) ? VEC_LO :
    (mem_addr == VEC_HIGH_ADDR) ? VEC_HI : ~junk_r;
  // pin low for a set number of oscillator edges
  task automatic hold_low(input int edges);
    reset_pin_n <= 1'b0;
    repeat (edges * 4) @(posedge clock);
    reset_pin_n <= 1'b1;
  endtask : hold_low
endmodule : reset_source_model

//--- sim/testbench.sv
// Self-checking bench for the reset entry and register initialisation block
`timescale 1ns/1ps
module testbench;
  import rst_init_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [15:0] mem_addr;
  logic mem_rd;
  logic [7:0] mem_rdata;
  logic main_osc_input;
  logic reset_pin_n;
  logic cpu_run;
  logic [15:0] start_pc;
  logic [39:0] port_data;
  logic [39:0] port_direction;
  logic [7:0] watchdog_control;
  logic [7:0] processor_mode_reg;
  logic [7:0] async_serial_control;
  logic [7:0] pulse_mod_control;
  logic [7:0] converter_control;
  logic wdog_running;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] d;
  int n_fail = 0;
  int compares = 0;
  int hits;
  always #25 clock = ~clock;
  reset_entry_and_register_init i_dut (.clock(clock), .rstn(rstn),
    .main_osc_input(main_osc_input), .reset_pin_n(reset_pin_n), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .cpu_run(cpu_run), .start_pc(start_pc),
    .port_data(port_data), .port_direction(port_direction),
    .watchdog_control(watchdog_control), .processor_mode_reg(processor_mode_reg),
    .async_serial_control(async_serial_control), .pulse_mod_control(pulse_mod_control),
    .converter_control(converter_control), .wdog_running(wdog_running),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  reset_source_model i_src (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .main_osc_input(main_osc_input), .reset_pin_n(reset_pin_n));
  // ****************************
  // Tasks
  // ****************************
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int i;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    avs_byteenable <= 4'hf;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      n_fail++;
      wrap_up();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v, exp);
  endtask : rd_chk
  // Reset values at the pins and through the bus
  task automatic check_rst();
    @(negedge clock);
    chk(port_data, 40'h0);
    chk(port_direction, 40'h0);
    chk({watchdog_control, processor_mode_reg}, 16'h3f48);
    chk({async_serial_control, pulse_mod_control, converter_control}, 24'he00010);
    chk(wdog_running, 1'b0);
    @(posedge clock);
    rd_chk(A_CTRL, 32'h1000e048);
    rd_chk(A_INTS, 32'h0);
    rd_chk(A_TIMERS, 32'h00000100);
    rd_chk(A_PRESC, 32'hffffffff);
    rd_chk(A_WDOG_CNT, 32'hff3fffff);
  endtask : check_rst
  // Synchronised release, then two vector fetches, then run
  task automatic expect_boot();
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge clock);
      if (mem_rd === 1'b1) break;
    end
    chk(i >= 2 && i < 20, 1'b1);
    if (i == 20) begin
      n_fail++;
      wrap_up();
    end
    chk(mem_addr, VEC_LOW_ADDR);
    @(negedge clock);
    chk({mem_rd, mem_addr}, {1'b1, VEC_HIGH_ADDR});
    @(negedge clock);
    chk({cpu_run, start_pc}, 17'h1c35a);
    @(posedge clock);
  endtask : expect_boot
  // ****************************
  // Main sequence
  // ****************************
  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    check_rst();
    // Writes while held in reset are overridden
    bus(1'b1, A_PORTS, 32'hffffffff, d);
    @(negedge clock);
    chk(port_data, 40'h0);
    @(posedge clock);
    // Pulse one edge short of the minimum must not release
    i_src.hold_low(19);
    hits = 0;
    repeat (40) begin
      @(negedge clock);
      if (mem_rd !== 1'b0 || cpu_run !== 1'b0) hits++;
    end
    chk(hits, 0);
    @(posedge clock);
    i_src.hold_low(20);
    expect_boot();
    rd_chk(A_VECTOR, 32'h0000c35a);
    rd_chk(4'h9, UNMAPPED_VAL);
    bus(1'b1, A_PORTS, 32'h44332211, d);
    @(negedge clock);
    chk(port_data, 40'h0044332211);
    @(posedge clock);
    bus(1'b1, A_SOFT_WR, 32'h000000c0, d);
    @(negedge clock);
    chk({wdog_running, watchdog_control}, 9'h1ff);
    @(posedge clock);
    // Second pin reset in mid-run restores every initialised register
    i_src.hold_low(20);
    expect_boot();
    check_rst();
    wrap_up();
  end
endmodule : testbench
